// ---- rtl/aicm_top.sv ----
// Purpose: Four-channel analog input monitor: scan sequencer, recorder timing, indicators.
// Assumes: Converter reports each sample with an over-span flag; controls are static-ish levels.
// Notes:   run_req is a pin and passes a three-stage synchroniser.
`timescale 1ns/10ps
module aicm_top #(
    parameter int unsigned CONV_CYC  = aicm_pkg::CONV_CYCLES,
    parameter int unsigned REC_CYC   = aicm_pkg::REC_BASE_CYC,
    parameter int unsigned BLINK_CYC = aicm_pkg::BLINK_CYCLES
) (
    input  wire logic         clk,
    input  wire logic         arst_n,
    input  wire logic         run_req,
    input  wire logic [3:0]   ch_en,
    input  wire logic [11:0]  range_sel,
    input  wire logic [3:0]   span_chk_dis,
    input  wire logic [3:0]   float_fmt,
    input  wire logic [27:0]  rec_ivl,
    input  wire logic [3:0]   peak_clr,
    input  wire logic         fault_serious,
    input  wire logic         fault_slight,
    input  wire logic [15:0]  adc_data,
    input  wire logic         adc_over_span,
    input  wire logic [8:0]   rec_rd_idx,
    output logic [1:0]        conv_ch,
    output logic              conv_busy,
    output logic [3:0]        disc_alarm,
    output logic [3:0]        span_err,
    output logic [63:0]       peak_max,
    output logic [63:0]       peak_min,
    output logic [3:0]        scale_en,
    output logic [35:0]       rec_count,
    output logic [63:0]       rec_rd_data,
    output logic              led_run,
    output logic              led_err,
    output logic              led_conv
);
    localparam int unsigned NCH = aicm_pkg::NUM_CH;

    logic [2:0]  sync_r, sync_nxt;
    logic        run_r, run_nxt;
    aicm_pkg::aicm_state_t st_r, st_nxt;
    logic [31:0] tmr_r, tmr_nxt;
    logic [1:0]  ch_r, ch_nxt;
    logic        svld_r, svld_nxt;
    logic [1:0]  svch_r, svch_nxt;
    logic [15:0] smp_r, smp_nxt;
    logic        ovr_r, ovr_nxt;
    logic [31:0] base_r, base_nxt;
    logic [6:0]  ivl_r [NCH];
    logic [6:0]  ivl_nxt [NCH];
    logic [NCH-1:0] tick;
    logic [31:0] blk_r, blk_nxt;
    logic        ph_r, ph_nxt;
    logic        base_tick;

    always_comb begin
        sync_nxt = {sync_r[1:0], run_req};
        run_nxt  = run_r;
        if (sync_r[2] == sync_r[1]) begin
            run_nxt = sync_r[2];
        end
    end

    // Scan: visit each enabled channel, dwell the conversion time on each
    always_comb begin
        st_nxt   = st_r;
        tmr_nxt  = tmr_r;
        ch_nxt   = ch_r;
        svld_nxt = 1'b0;
        svch_nxt = svch_r;
        smp_nxt  = smp_r;
        ovr_nxt  = ovr_r;
        case (st_r)
            aicm_pkg::AICM_ST_STOP: begin
                if (run_r) begin
                    st_nxt = aicm_pkg::AICM_ST_WAIT;
                end
            end
            aicm_pkg::AICM_ST_WAIT: begin
                if (!run_r) begin
                    st_nxt = aicm_pkg::AICM_ST_STOP;
                end else if (ch_en[ch_r]) begin
                    st_nxt  = aicm_pkg::AICM_ST_CONV;
                    tmr_nxt = '0;
                end else begin
                    ch_nxt = ch_r + 2'h1;
                end
            end
            aicm_pkg::AICM_ST_CONV: begin
                if (tmr_r == CONV_CYC - 1) begin
                    // Capture while conv_ch still names the converted channel
                    svld_nxt = 1'b1;
                    svch_nxt = ch_r;
                    smp_nxt  = adc_data;
                    ovr_nxt  = adc_over_span;
                    ch_nxt   = ch_r + 2'h1;
                    st_nxt   = aicm_pkg::AICM_ST_WAIT;
                end else begin
                    tmr_nxt = tmr_r + 32'h1;
                end
            end
            default: st_nxt = aicm_pkg::AICM_ST_STOP;
        endcase
    end

    // Record base tick, then per-channel interval divider
    always_comb begin
        base_tick = run_r && (base_r == REC_CYC - 1);
        base_nxt  = (!run_r || base_tick) ? '0 : base_r + 32'h1;
        for (int i = 0; i < NCH; i++) begin
            logic [6:0] lim;
            lim = rec_ivl[i*7 +: 7];
            if (lim < 7'(aicm_pkg::REC_IVL_MIN)) begin
                lim = 7'(aicm_pkg::REC_IVL_MIN);
            end else if (lim > 7'(aicm_pkg::REC_IVL_MAX)) begin
                lim = 7'(aicm_pkg::REC_IVL_MAX);
            end
            tick[i]    = base_tick && ch_en[i] && (ivl_r[i] + 7'h1 >= lim);
            ivl_nxt[i] = !run_r ? '0 : (tick[i] ? '0 : (base_tick ? ivl_r[i] + 7'h1 : ivl_r[i]));
        end
    end

    // Shared blink prescaler
    always_comb begin
        blk_nxt = blk_r + 32'h1;
        ph_nxt  = ph_r;
        if (blk_r == BLINK_CYC - 1) begin
            blk_nxt = '0;
            ph_nxt  = !ph_r;
        end
    end

    // Run synchroniser
    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            sync_r <= '0;
            run_r  <= 1'b0;
        end else begin
            sync_r <= sync_nxt;
            run_r  <= run_nxt;
        end
    end

    // Scan sequencer and sample pipeline
    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            st_r   <= aicm_pkg::AICM_ST_STOP;
            tmr_r  <= '0;
            ch_r   <= '0;
            svld_r <= 1'b0;
            svch_r <= '0;
            smp_r  <= '0;
            ovr_r  <= 1'b0;
        end else begin
            st_r   <= st_nxt;
            tmr_r  <= tmr_nxt;
            ch_r   <= ch_nxt;
            svld_r <= svld_nxt;
            svch_r <= svch_nxt;
            smp_r  <= smp_nxt;
            ovr_r  <= ovr_nxt;
        end
    end

    // Record timing
    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            base_r <= '0;
            for (int i = 0; i < NCH; i++) begin
                ivl_r[i] <= '0;
            end
        end else begin
            base_r <= base_nxt;
            for (int i = 0; i < NCH; i++) begin
                ivl_r[i] <= ivl_nxt[i];
            end
        end
    end

    // Blink prescaler
    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            blk_r <= '0;
            ph_r  <= 1'b0;
        end else begin
            blk_r <= blk_nxt;
            ph_r  <= ph_nxt;
        end
    end

    for (genvar g = 0; g < NCH; g++) begin : g_ch
        aicm_chan #(
            .DW    (aicm_pkg::DATA_W),
            .DEPTH (aicm_pkg::REC_DEPTH),
            .AW    (9)
        ) u_chan (
            .clk          (clk),
            .arst_n       (arst_n),
            .range_sel    (range_sel[g*3 +: 3]),
            .span_chk_dis (span_chk_dis[g]),
            .float_fmt    (float_fmt[g]),
            .sample_vld   (svld_r && (svch_r == 2'(g))),
            .sample       (smp_r),
            .over_span    (ovr_r),
            .rec_tick     (tick[g]),
            .peak_clr     (peak_clr[g]),
            .rec_rd_idx   (rec_rd_idx),
            .disc_alarm   (disc_alarm[g]),
            .span_err     (span_err[g]),
            .peak_max     (peak_max[g*16 +: 16]),
            .peak_min     (peak_min[g*16 +: 16]),
            .scale_en     (scale_en[g]),
            .rec_count    (rec_count[g*9 +: 9]),
            .rec_rd_data  (rec_rd_data[g*16 +: 16])
        );
    end

    assign conv_ch   = ch_r;
    assign conv_busy = (st_r == aicm_pkg::AICM_ST_CONV);
    assign led_run   = run_r;
    assign led_err   = fault_serious | (fault_slight & ph_r);
    assign led_conv  = (st_r != aicm_pkg::AICM_ST_STOP) & ph_r;
endmodule

// ---- rtl/aicm_pkg.sv ----
// Purpose: Constants and types for the four-channel analog input monitor.
// Assumes: 100 MHz module clock, 16-bit signed converter samples.
// Notes:   Timing counts assume the 100 MHz module clock.
// Function
// - Disconnection check only in live-zero current or live-zero voltage range.
// - Disconnected live-zero input falls out of span and raises channel alarm.
// - Input beyond receivable span flags a readable per-channel error.
// - Per-channel disable suppresses the out-of-range alarm entirely.
// - Keep per-channel largest and smallest converted value for peak-to-peak.
// - Record cyclic samples per channel, up to 500 entries, 10 ms base.
// - Scale range applies only when channel format is floating point.
// - Run indicator on while operating, off while stopped.
// - Error indicator steady for serious, blinking for slight, off otherwise.
// - Conversion indicator blinks during conversion, off when stopped.
// - Each enabled channel takes 2 ms to convert; scan time scales with count.
// - Record interval 1 to 100 units of 10 ms; record count 0 to 500.
package aicm_pkg;
    localparam int unsigned CLK_HZ        = 100_000_000;
    localparam int unsigned CONV_TIME_US  = 2000;
    localparam int unsigned CONV_CYCLES   = CLK_HZ / 1_000_000 * CONV_TIME_US;
    localparam int unsigned REC_BASE_US   = 10000;
    localparam int unsigned REC_BASE_CYC  = CLK_HZ / 1_000_000 * REC_BASE_US;
    localparam int unsigned BLINK_MS      = 250;
    localparam int unsigned BLINK_CYCLES  = CLK_HZ / 1000 * BLINK_MS;
    localparam int unsigned REC_DEPTH     = 500;
    localparam int unsigned REC_IVL_MIN   = 1;
    localparam int unsigned REC_IVL_MAX   = 100;
    localparam int unsigned NUM_CH        = 4;
    localparam int unsigned DATA_W        = 16;
    localparam logic [15:0] PEAK_MAX_RST  = 16'h8000;
    localparam logic [15:0] PEAK_MIN_RST  = 16'h7FFF;

    typedef enum logic [2:0] {
        AICM_RANGE_BIP10V  = 3'h0,
        AICM_RANGE_UNI10V  = 3'h1,
        AICM_RANGE_BIP5V   = 3'h2,
        AICM_RANGE_LZ5V    = 3'h3,
        AICM_RANGE_LZ20MA  = 3'h4,
        AICM_RANGE_BIP20MA = 3'h5,
        AICM_RANGE_UNI20MA = 3'h6,
        AICM_RANGE_UNI5V   = 3'h7
    } aicm_range_t;

    typedef enum logic [1:0] {
        AICM_ST_STOP = 2'h0,
        AICM_ST_WAIT = 2'h1,
        AICM_ST_CONV = 2'h2
    } aicm_state_t;
endpackage

// ---- rtl/aicm_chan.sv ----
// Purpose: Per-channel supervision: span alarm, peaks, scale gating, recorder.
// Assumes: sample_vld is a one-cycle pulse from the scan sequencer.
// Notes:   Recorder is a ring; oldest entry is overwritten once full.
`timescale 1ns/10ps
module aicm_chan #(
    parameter int unsigned DW    = 16,
    parameter int unsigned DEPTH = 500,
    parameter int unsigned AW    = 9
) (
    input  wire logic          clk,
    input  wire logic          arst_n,
    input  wire logic [2:0]    range_sel,
    input  wire logic          span_chk_dis,
    input  wire logic          float_fmt,
    input  wire logic          sample_vld,
    input  wire logic [DW-1:0] sample,
    input  wire logic          over_span,
    input  wire logic          rec_tick,
    input  wire logic          peak_clr,
    input  wire logic [AW-1:0] rec_rd_idx,
    output logic               disc_alarm,
    output logic               span_err,
    output logic [DW-1:0]      peak_max,
    output logic [DW-1:0]      peak_min,
    output logic               scale_en,
    output logic [AW-1:0]      rec_count,
    output logic [DW-1:0]      rec_rd_data
);
    logic [DW-1:0] mem [DEPTH];
    logic          disc_r, disc_nxt, err_r, err_nxt;
    logic [DW-1:0] max_r, max_nxt, min_r, min_nxt, last_r, last_nxt, rd_r;
    logic [AW-1:0] wp_r, wp_nxt, cnt_r, cnt_nxt;
    logic          live_zero;

    always_comb begin
        live_zero = (range_sel == aicm_pkg::AICM_RANGE_LZ20MA) ||
                    (range_sel == aicm_pkg::AICM_RANGE_LZ5V);
        disc_nxt = disc_r;
        err_nxt  = err_r;
        max_nxt  = max_r;
        min_nxt  = min_r;
        last_nxt = last_r;
        if (sample_vld) begin
            disc_nxt = live_zero && over_span && !span_chk_dis;
            err_nxt  = over_span && !span_chk_dis;
            last_nxt = sample;
            if ($signed(sample) > $signed(max_nxt)) begin
                max_nxt = sample;
            end
            if ($signed(sample) < $signed(min_nxt)) begin
                min_nxt = sample;
            end
        end
        if (span_chk_dis) begin
            disc_nxt = 1'b0;
            err_nxt  = 1'b0;
        end
        if (peak_clr) begin
            max_nxt = aicm_pkg::PEAK_MAX_RST;
            min_nxt = aicm_pkg::PEAK_MIN_RST;
        end
        wp_nxt  = wp_r;
        cnt_nxt = cnt_r;
        if (rec_tick) begin
            wp_nxt = (wp_r == AW'(DEPTH - 1)) ? '0 : wp_r + 1'b1;
            if (cnt_r != AW'(DEPTH)) begin
                cnt_nxt = cnt_r + 1'b1;
            end
        end
    end

    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            disc_r <= 1'b0;
            err_r  <= 1'b0;
            max_r  <= aicm_pkg::PEAK_MAX_RST;
            min_r  <= aicm_pkg::PEAK_MIN_RST;
            last_r <= '0;
            wp_r   <= '0;
            cnt_r  <= '0;
        end else begin
            disc_r <= disc_nxt;
            err_r  <= err_nxt;
            max_r  <= max_nxt;
            min_r  <= min_nxt;
            last_r <= last_nxt;
            wp_r   <= wp_nxt;
            cnt_r  <= cnt_nxt;
        end
    end

    // Memory kept out of reset so it maps to block RAM
    always_ff @(posedge clk) begin
        if (rec_tick) begin
            mem[wp_r] <= last_r;
        end
        rd_r <= mem[rec_rd_idx];
    end

    assign disc_alarm  = disc_r;
    assign span_err    = err_r;
    assign peak_max    = max_r;
    assign peak_min    = min_r;
    assign scale_en    = float_fmt;
    assign rec_count   = cnt_r;
    assign rec_rd_data = rd_r;
endmodule

// ---- bench/aicm_assertions.sv ----
// Purpose: Port-level checks for the analog input monitor.
// Assumes: Bench-sized CONV_CYC handed on by the bind.
// Notes:   Sequencer state is seen only through conv_busy and conv_ch.
`timescale 1ns/10ps
module aicm_checker #(
    parameter int unsigned CONV_CYC = 20
) (
    input wire logic        clk,
    input wire logic        arst_n,
    input wire logic        run_req,
    input wire logic [3:0]  ch_en,
    input wire logic [3:0]  span_chk_dis,
    input wire logic [3:0]  float_fmt,
    input wire logic        fault_serious,
    input wire logic        fault_slight,
    input wire logic [1:0]  conv_ch,
    input wire logic        conv_busy,
    input wire logic [3:0]  disc_alarm,
    input wire logic [3:0]  span_err,
    input wire logic [3:0]  scale_en,
    input wire logic [35:0] rec_count,
    input wire logic        led_run,
    input wire logic        led_err,
    input wire logic        led_conv
);
    logic [31:0] busy_cnt_r;
    logic [31:0] busy_cnt_nxt;
    always_comb busy_cnt_nxt = conv_busy ? busy_cnt_r + 32'h1 : 32'h0;
    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) busy_cnt_r <= 32'h0;
        else busy_cnt_r <= busy_cnt_nxt;
    end
    default clocking @(posedge clk); endclocking
    default disable iff (!arst_n);
    a_disc_in_span: assert property ((disc_alarm & ~span_err) == 4'h0)
        else $error("disconnection alarm without span error");
    a_dis_clears_err: assert property (|span_chk_dis |=> (span_err & $past(span_chk_dis)) == 4'h0)
        else $error("span error on a disabled channel");
    a_scale_float: assert property (scale_en == float_fmt)
        else $error("scale enable differs from float format");
    a_run_led_sync: assert property ($rose(led_run) |-> $past(run_req, 2))
        else $error("run indicator rose without run request");
    a_serious_steady: assert property (fault_serious ##1 fault_serious |-> led_err)
        else $error("error indicator off during serious fault");
    a_no_fault_dark: assert property (!(fault_serious || fault_slight) [*2] |-> !led_err)
        else $error("error indicator on without fault");
    a_blink_shared: assert property ((fault_slight && !fault_serious) [*2] ##0 led_conv |-> led_err)
        else $error("indicators out of blink phase");
    a_conv_length: assert property ($fell(conv_busy) |-> busy_cnt_r == CONV_CYC)
        else $error("conversion slot of wrong length");
    a_busy_enabled: assert property (conv_busy |-> ch_en[conv_ch])
        else $error("conversion on a disabled channel");
    a_count_limit: assert property (rec_count[8:0] <= 9'h1F4 && rec_count[17:9] <= 9'h1F4 &&
        rec_count[26:18] <= 9'h1F4 && rec_count[35:27] <= 9'h1F4) else $error("record count above limit");
endmodule

// ---- bench/aicm_xducer.sv ----
// Purpose: Field transducer model on the converter input.
// Assumes: Converter samples whatever the selected channel presents.
// Notes:   Bench sets each channel's level and over-span state.
`timescale 1ns/10ps
module aicm_xducer (
    input  wire logic [1:0]  conv_ch,
    input  wire logic [63:0] level,
    input  wire logic [3:0]  broken,
    output logic [15:0]      adc_data,
    output logic             adc_over_span
);
    // A cut wire reads out of span
    always_comb begin
        adc_data      = level[conv_ch*16 +: 16];
        adc_over_span = broken[conv_ch];
    end
endmodule

// ---- bench/testbench.sv ----
// Purpose: Self-checking bench for the analog input monitor.
// Assumes: Shortened conversion, record and blink counts.
// Notes:   Inputs change on the falling edge only.
`timescale 1ns/10ps
module testbench;
    localparam int unsigned CONV_CYC = 20;
    logic        clk, arst_n, run_req, fault_serious, fault_slight, adc_over_span, conv_busy;
    logic        led_run, led_err, led_conv;
    logic [3:0]  ch_en, span_chk_dis, float_fmt, peak_clr, disc_alarm, span_err, scale_en, broken;
    logic [11:0] range_sel;
    logic [27:0] rec_ivl;
    logic [15:0] adc_data;
    logic [8:0]  rec_rd_idx;
    logic [1:0]  conv_ch, s;
    logic [63:0] peak_max, peak_min, rec_rd_data, level;
    logic [35:0] rec_count;
    int          fails = 0;
    int          comparisons = 0;

    aicm_top #(.CONV_CYC(CONV_CYC), .REC_CYC(50), .BLINK_CYC(4)) dut_u (.clk, .arst_n, .run_req, .ch_en,
        .range_sel, .span_chk_dis, .float_fmt, .rec_ivl, .peak_clr, .fault_serious, .fault_slight,
        .adc_data, .adc_over_span, .rec_rd_idx, .conv_ch, .conv_busy, .disc_alarm, .span_err,
        .peak_max, .peak_min, .scale_en, .rec_count, .rec_rd_data, .led_run, .led_err, .led_conv);
    aicm_xducer field_u (.conv_ch, .level, .broken, .adc_data, .adc_over_span);

    task automatic chk(input string what, input logic [63:0] seen, input logic [63:0] exp);
        comparisons++;
        if (seen !== exp) begin
            fails++;
            $display("MISMATCH %s expected %h seen %h", what, exp, seen);
        end
    endtask
    task automatic end_of_test;
        $display("comparisons %0d mismatches %0d", comparisons, fails);
        if (fails == 0 && comparisons > 0) $display("TB: PASS");
        else $display("TB: FAIL");
        $finish;
    endtask
    task automatic cyc(input int n);
        repeat (n) @(negedge clk);
    endtask
    task automatic wait_run(input logic lvl);
        for (int i = 0; i < 20 && led_run !== lvl; i++) cyc(1);
        if (led_run !== lvl) begin
            fails++;
            end_of_test();
        end
    endtask
    // Blink seen only if both levels appear within a few half periods
    task automatic blink(input bit conv, output logic [1:0] seen);
        seen = 2'b00;
        repeat (12) begin
            cyc(1);
            if ((conv ? led_conv : led_err) === 1'b1) seen[1] = 1'b1;
            if ((conv ? led_conv : led_err) === 1'b0) seen[0] = 1'b1;
        end
    endtask

    initial begin
        clk = 1'b0;
        forever #5 clk = ~clk;
    end
    initial begin
        arst_n = 1'b0; run_req = 1'b0; ch_en = 4'hB; span_chk_dis = 4'h0; float_fmt = 4'h0;
        range_sel = {3'h3, 3'h0, 3'h0, 3'h4}; rec_ivl = {7'h64, 7'h01, 7'h00, 7'h01};
        peak_clr = 4'h0; fault_serious = 1'b0; fault_slight = 1'b0; rec_rd_idx = 9'h000;
        level = {16'h1234, 16'h5555, 16'hFF00, 16'h0100}; broken = 4'h3;
        cyc(2);
        arst_n = 1'b1;
        chk("peak_max reset", peak_max, {4{16'h8000}});
        chk("peak_min reset", peak_min, {4{16'h7FFF}});
        chk("led_conv idle", led_conv, 1'b0);
        run_req = 1'b1;
        wait_run(1'b1);
        chk("led_run on", led_run, 1'b1);
        blink(1'b1, s);
        chk("led_conv blink", s, 2'b11);
        cyc(200);
        chk("disc_alarm", disc_alarm, 4'h1);
        chk("span_err", span_err, 4'h3);
        chk("peak_max", peak_max, {16'h1234, 16'h8000, 16'hFF00, 16'h0100});
        level = {16'h0010, 16'h5555, 16'h0200, 16'h0100};
        cyc(200);
        chk("peak_max new", peak_max, {16'h1234, 16'h8000, 16'h0200, 16'h0100});
        chk("peak_min new", peak_min, {16'h0010, 16'h7FFF, 16'hFF00, 16'h0100});
        span_chk_dis = 4'h3;
        cyc(2);
        chk("alarms disabled", {disc_alarm, span_err}, 8'h00);
        float_fmt = 4'h5;
        cyc(1);
        chk("scale_en", scale_en, 4'h5);
        cyc(1);
        chk("record ch0 ch1", rec_rd_data[31:0], {16'hFF00, 16'h0100});
        chk("count disabled ch", rec_count[26:18], 9'h000);
        cyc(26000);
        chk("count ch0 full", rec_count[8:0], 9'h1F4);
        chk("count ch1 clamped", rec_count[17:9], 9'h1F4);
        chk("count ch3 slow", rec_count[35:27] < 9'h00A, 1'b1);
        fault_serious = 1'b1;
        fault_slight = 1'b1;
        cyc(3);
        blink(1'b0, s);
        chk("led_err steady", s, 2'b10);
        fault_serious = 1'b0;
        cyc(2);
        blink(1'b0, s);
        chk("led_err blink", s, 2'b11);
        fault_slight = 1'b0;
        cyc(2);
        blink(1'b0, s);
        chk("led_err off", s, 2'b01);
        run_req = 1'b0;
        wait_run(1'b0);
        chk("led_run off", led_run, 1'b0);
        cyc(60);
        blink(1'b1, s);
        chk("led_conv stopped", s, 2'b01);
        peak_clr = 4'h8;
        cyc(1);
        peak_clr = 4'h0;
        cyc(1);
        chk("peak clear", {peak_max[63:48], peak_min[63:48]}, 32'h80007FFF);
        end_of_test();
    end
endmodule

bind aicm_top aicm_checker #(.CONV_CYC(CONV_CYC)) chk_u (.clk, .arst_n, .run_req, .ch_en, .span_chk_dis,
    .float_fmt, .fault_serious, .fault_slight, .conv_ch, .conv_busy, .disc_alarm, .span_err, .scale_en,
    .rec_count, .led_run, .led_err, .led_conv);
